/* File: core/tmc_codec.sv */
`timescale 1ns/10ps
`default_nettype none
`include "tmc_map.svh"

module tmc_fifo #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 16
) (
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wptr_r;
    logic [AW-1:0]    rptr_r;
    logic [AW:0]      cnt_r;
    logic [AW:0]      cnt_nxt;
    logic             full_r;
    logic             empty_r;
    logic             in_rdy_r;
    wire              push = i_in_valid && !full_r;
    wire              pop  = i_out_ready && !empty_r;

    assign cnt_nxt     = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    assign o_in_ready  = in_rdy_r;
    assign o_out_valid = !empty_r;
    assign o_out_data  = mem[rptr_r];

    always_ff @(posedge i_ref_clk)
    begin
        if (push)
            mem[wptr_r] <= i_in_data;
    end

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wptr_r  <= '0;
            rptr_r  <= '0;
            cnt_r   <= '0;
            full_r  <= 1'b0;
            empty_r <= 1'b1;
            in_rdy_r <= 1'b1;
        end
        else
        begin
            wptr_r  <= wptr_r + AW'(push);
            rptr_r  <= rptr_r + AW'(pop);
            cnt_r   <= cnt_nxt;
            full_r  <= (cnt_nxt == (AW+1)'(DEPTH));
            empty_r <= (cnt_nxt == '0);
            in_rdy_r <= (cnt_nxt != (AW+1)'(DEPTH));
        end
    end

    a_fifo_bound: assert property (@(posedge i_ref_clk) disable iff (i_rst) cnt_r <= (AW+1)'(DEPTH))
        else $error("buffer count beyond depth");
    a_fifo_ready: assert property (@(posedge i_ref_clk) disable iff (i_rst) o_in_ready == !full_r)
        else $error("buffer ready disagrees with fill");
endmodule : tmc_fifo

module tmc_codec
    import tmc_pkg::*;
(
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_rst,
    input  wire logic [`TMC_UNIT_W-1:0] i_unit,
    input  wire logic                   i_select,
    input  wire logic                   i_go,
    input  wire logic                   i_write,
    input  wire tmc_trk_t               i_trk,
    output logic [`TMC_UNITS-1:0]       o_unit_sel,
    output logic [`TMC_GRP_W-1:0]       o_wr_cur,
    output logic                        o_wr_en,
    input  wire logic                   i_wb_valid,
    output logic                        o_wb_ready,
    input  wire logic [`TMC_BYTE_W-1:0] i_wb_data,
    output logic                        o_underrun,
    output logic                        o_rd_valid,
    output logic [`TMC_BYTE_W-1:0]      o_rd_byte,
    output tmc_mark_t                   o_mark,
    output logic                        o_aligned,
    output logic                        o_mark_err,
    output logic                        o_label_done,
    output logic [`TMC_LABEL_W-1:0]     o_label,
    output logic                        o_label_std
);
    // Membership in the symmetric code set
    function automatic logic is_mark(input logic [`TMC_CODE_W-1:0] c);
        case (c)
            `TMC_CODE_RDE, `TMC_CODE_FEND, `TMC_CODE_SPACE, `TMC_CODE_LEND,
            `TMC_CODE_DSYNC, `TMC_CODE_RLEND, `TMC_CODE_LSYNC, `TMC_CODE_REND,
            `TMC_CODE_DMARK, `TMC_CODE_FDE:
                is_mark = 1'b1;
            default:
                is_mark = 1'b0;
        endcase
    endfunction : is_mark

    // Pin synchronisers
    tmc_trk_t trk_m_r;
    tmc_trk_t trk_s_r;
    logic     tim_d_r;
    // Edges stay masked until the synchroniser holds real pin levels
    logic [`TMC_PRIME_W-1:0] prime_r;
    wire                     primed = prime_r[`TMC_PRIME_W-1];

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            trk_m_r <= '0;
            trk_s_r <= '0;
            tim_d_r <= 1'b0;
            prime_r <= '0;
        end
        else
        begin
            trk_m_r <= i_trk;
            trk_s_r <= trk_m_r;
            tim_d_r <= trk_s_r.tim;
            prime_r <= {prime_r[`TMC_PRIME_W-2:0], 1'b1};
        end
    end

    wire tim_pos = primed && trk_s_r.tim && !tim_d_r;
    wire tim_neg = primed && !trk_s_r.tim && tim_d_r;

    // Mode
    tmc_mode_t mode_r;
    tmc_mode_t mode_nxt;
    assign mode_nxt = !i_go    ? TMC_IDLE :
                      i_write  ? TMC_WRITE : TMC_READ;
    wire rd_mode = (mode_r == TMC_READ);
    wire wr_mode = (mode_r == TMC_WRITE);

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            mode_r <= TMC_IDLE;
        else
            mode_r <= mode_nxt;
    end

    // Drive selection
    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
            o_unit_sel <= '0;
        else
            o_unit_sel <= i_select ? (`TMC_UNITS'(1) << i_unit) : '0;
    end

    // Write path
    logic                    fifo_valid;
    logic [`TMC_BYTE_W-1:0]  fifo_data;
    logic                    hi_done_r;
    wire                     wr_load = wr_mode && tim_neg;
    wire                     wr_pop  = wr_load && hi_done_r;
    wire [`TMC_GRP_W-1:0]    wr_next = !fifo_valid ? '0 :
                                       hi_done_r ? fifo_data[`TMC_GRP_W-1:0]
                                                 : fifo_data[`TMC_BYTE_W-1:`TMC_GRP_W];

    tmc_fifo #(
        .WIDTH (`TMC_BYTE_W),
        .DEPTH (`TMC_FIFO_DEPTH)
    ) u_fifo (
        .i_ref_clk   (i_ref_clk),
        .i_rst       (i_rst),
        .i_in_valid  (i_wb_valid),
        .o_in_ready  (o_wb_ready),
        .i_in_data   (i_wb_data),
        .o_out_valid (fifo_valid),
        .i_out_ready (wr_pop),
        .o_out_data  (fifo_data)
    );

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            hi_done_r  <= 1'b0;
            o_wr_cur   <= '0;
            o_wr_en    <= 1'b0;
            o_underrun <= 1'b0;
        end
        else
        begin
            o_wr_en    <= wr_mode;
            o_underrun <= wr_load && !fifo_valid;
            if (!wr_mode)
                hi_done_r <= 1'b0;
            else if (wr_load && fifo_valid)
                hi_done_r <= !hi_done_r;
            if (wr_load)
            begin
                o_wr_cur <= ~wr_next;
            end
            else if (wr_mode && tim_pos)
                o_wr_cur <= ~o_wr_cur;
        end
    end

    // Read sampling
    wire rd_strobe = rd_mode && tim_pos;
    logic [`TMC_GRP_W-1:0]   rhi_r;
    logic                    rhalf_r;
    logic [`TMC_CODE_W-1:0]  shift_r;
    logic [`TMC_LABEL_W-1:0] lshift_r;
    wire  [`TMC_CODE_W-1:0]  shift_nxt = {shift_r[`TMC_CODE_W-2:0], trk_s_r.mark};
    wire                     hit       = rd_strobe && is_mark(shift_nxt);
    wire                     is_space  = (shift_nxt == `TMC_CODE_SPACE);
    wire                     frame_hit = hit && !is_space;
    wire  [`TMC_LABEL_W-1:0] lab_nxt   = {lshift_r[`TMC_LABEL_W-`TMC_GRP_W-1:0], trk_s_r.data};

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rhi_r      <= '0;
            rhalf_r    <= 1'b0;
            shift_r    <= '0;
            lshift_r   <= '0;
            o_rd_valid <= 1'b0;
            o_rd_byte  <= '0;
        end
        else
        begin
            o_rd_valid <= rd_strobe && rhalf_r && !frame_hit;
            if (rd_strobe)
            begin
                shift_r  <= shift_nxt;
                lshift_r <= lab_nxt;
                if (frame_hit)
                    rhalf_r <= 1'b0;
                else
                    rhalf_r <= !rhalf_r;
                if (!rhalf_r)
                    rhi_r <= trk_s_r.data;
                else
                    o_rd_byte <= {rhi_r, trk_s_r.data};
            end
        end
    end

    // Alignment and six-position check
    logic [2:0] pos_r;
    logic       armed_r;

    always_ff @(posedge i_ref_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pos_r        <= '0;
            o_aligned    <= 1'b0;
            o_mark_err   <= 1'b0;
            o_mark       <= '0;
            armed_r      <= 1'b0;
            o_label_done <= 1'b0;
            o_label      <= '0;
            o_label_std  <= 1'b0;
        end
        else
        begin
            o_mark.valid <= hit;
            if (hit)
                o_mark.code <= shift_nxt;
            o_mark_err   <= 1'b0;
            o_label_done <= 1'b0;
            if (!rd_mode)
            begin
                o_aligned <= 1'b0;
                pos_r     <= '0;
                armed_r   <= 1'b0;
            end
            else if (rd_strobe)
            begin
                if (frame_hit)
                begin
                    o_aligned <= 1'b1;
                    pos_r     <= '0;
                end
                else if (hit)
                    pos_r <= '0;
                else if (pos_r == `TMC_MARK_POS - 3'h1)
                begin
                    pos_r      <= '0;
                    o_mark_err <= o_aligned;
                end
                else
                    pos_r <= pos_r + 3'h1;
                if (hit && shift_nxt == `TMC_CODE_LSYNC)
                    armed_r <= 1'b1;
                if (hit && shift_nxt == `TMC_CODE_LEND)
                begin
                    armed_r      <= 1'b0;
                    o_label_done <= armed_r;
                    if (armed_r)
                    begin
                        o_label     <= lab_nxt;
                        o_label_std <= (lab_nxt >= `TMC_LABEL_FIRST) && (lab_nxt <= `TMC_LABEL_LAST);
                    end
                end
            end
        end
    end

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    a_sel_onehot: assert property (i_select |=> $onehot(o_unit_sel))
        else $error("unit select not one-hot");
    a_neg_load_wr: assert property (!wr_mode |-> !wr_load)
        else $error("write buffer loaded outside writing");
    a_pos_flip: assert property (wr_mode && tim_pos && !wr_load |=> o_wr_cur == ~$past(o_wr_cur))
        else $error("write current not flipped");
    a_cur_hold: assert property (!wr_load && !(wr_mode && tim_pos) |=> $stable(o_wr_cur))
        else $error("write current moved without timing edge");
    a_rd_idle: assert property (!rd_mode |=> !o_rd_valid && !o_mark.valid)
        else $error("read output outside reading");
    a_mark_valid: assert property (o_mark.valid |-> is_mark(o_mark.code))
        else $error("invalid mark code reported");
    a_label_done: assert property (o_label_done |-> $past(armed_r, 1) && o_mark.code == `TMC_CODE_LEND)
        else $error("label done without armed terminator");
    a_err_aligned: assert property (o_mark_err |-> $past(o_aligned))
        else $error("mark error before alignment");
    a_space_noreset: assert property (rd_strobe && hit && is_space && rhalf_r |=> !rhalf_r)
        else $error("spacer disturbed byte pairing");
    a_sel_off: assert property (!i_select |=> o_unit_sel == '0)
        else $error("drive selected while deselect requested");
    a_rd_pair: assert property (o_rd_valid |-> $past(rhalf_r) && !$past(frame_hit))
        else $error("byte released without a first half");
    a_align_drop: assert property (!rd_mode |=> !o_aligned)
        else $error("alignment kept outside reading");
    a_underrun_zero: assert property (wr_load && !fifo_valid |=> o_wr_cur == '1)
        else $error("empty buffer load did not write zeros");
    a_neg_ignored: assert property (rd_mode && tim_neg |=> $stable(o_rd_byte) && !o_rd_valid)
        else $error("falling timing edge acted on while reading");
    a_wr_en_mode: assert property (o_wr_en == $past(wr_mode))
        else $error("write enable out of step with mode");
    a_label_stable: assert property (!o_label_done |-> $stable(o_label))
        else $error("label changed without terminator");
    a_std_stable: assert property (!o_label_done |-> $stable(o_label_std))
        else $error("label range flag changed without terminator");
    a_mark_hold: assert property (!o_mark.valid |-> $stable(o_mark.code))
        else $error("mark code changed without a match");
    a_mark_pulse: assert property (o_mark.valid |=> !o_mark.valid)
        else $error("mark valid longer than one cycle");
    a_rd_pulse: assert property (o_rd_valid |=> !o_rd_valid)
        else $error("read valid longer than one cycle");
    a_err_pulse: assert property (o_mark_err |=> !o_mark_err)
        else $error("mark error longer than one cycle");
    a_done_pulse: assert property (o_label_done |=> !o_label_done)
        else $error("label done longer than one cycle");
    a_underrun_mode: assert property (o_underrun |-> o_wr_en)
        else $error("underrun reported outside writing");
    a_space_align: assert property (rd_strobe && is_space && !o_aligned |=> !o_aligned)
        else $error("spacer set alignment");
    a_pos_range: assert property (pos_r < `TMC_MARK_POS)
        else $error("position counter out of range");
    a_align_source: assert property ($rose(o_aligned) |-> $past(frame_hit))
        else $error("alignment without a framing mark");
    a_armed_clear: assert property (!rd_mode |=> !armed_r)
        else $error("label capture armed outside reading");
endmodule : tmc_codec

`default_nettype wire

/* File: pkg/tmc_map.svh */
// Behaviour
// - Select one of eight tape drives from four dual transport units.
// - Split each 6-bit byte into two 3-bit groups; rejoin them when reading.
// - Five channels: three data, timing and mark, each on redundant tracks.
// - Negative timing transition loads the write buffer only while writing.
// - Positive timing transition flips write current on all heads while writing.
// - Positive timing transition samples data and mark reads while reading.
// - A sampled positive transition stores one, anything else stores zero.
// - Mark codes are serial, six consecutive bit positions per code.
// - Reverse motion presents codes bit-reversed and inverted.
// - One recognizer serves both directions through the symmetric code set.
// - Mark bits shift into a register compared against the valid codes.
// - Only the spacer code matches at partial positions; match every shift.
// - Regain mark alignment from any start point without a sync procedure.
// - A 36-bit word spans 12 tape positions beside two mark codes.
// - An 18-bit inter-block slot carries a single mark code.
// - Standard labels run 1 to octal 1100, dummies 0 and octal 1101.
// - A block label sits beside spacer octal 25 then terminator octal 26.
// - The terminator code marks completion of the label transfer.
// - The spacer triggers no action in either direction.
// - Spacer repeats closer than six positions are not errors.
// - Label capture is armed by the sync code inside the preceding block.
// - Block length comes from the mark channel, never from fixed logic.
// - Inside a block a valid code must appear every six mark positions.
`ifndef TMC_MAP_SVH
`define TMC_MAP_SVH
`define TMC_UNITS        8
`define TMC_UNIT_W       3
`define TMC_GRP_W        3
`define TMC_BYTE_W       6
`define TMC_CODE_W       6
`define TMC_MARK_POS     3'h6
`define TMC_LABEL_W      36
`define TMC_FIFO_DEPTH   16
`define TMC_PRIME_W      3
`define TMC_CODE_RDE     6'h08
`define TMC_CODE_FEND    6'h12
`define TMC_CODE_SPACE   6'h15
`define TMC_CODE_LEND    6'h16
`define TMC_CODE_DSYNC   6'h1A
`define TMC_CODE_RLEND   6'h25
`define TMC_CODE_LSYNC   6'h29
`define TMC_CODE_REND    6'h2D
`define TMC_CODE_DMARK   6'h38
`define TMC_CODE_FDE     6'h3B
`define TMC_LABEL_FIRST  36'h000000001
`define TMC_LABEL_LAST   36'h000000240
`endif

/* File: pkg/tmc_pkg.sv */
`include "tmc_map.svh"
package tmc_pkg;
    typedef struct packed {
        logic                  tim;
        logic                  mark;
        logic [`TMC_GRP_W-1:0] data;
    } tmc_trk_t;

    typedef struct packed {
        logic                   valid;
        logic [`TMC_CODE_W-1:0] code;
    } tmc_mark_t;

    typedef enum logic [2:0] {
        TMC_IDLE  = 3'h1,
        TMC_READ  = 3'h2,
        TMC_WRITE = 3'h4
    } tmc_mode_t;
endpackage : tmc_pkg

/* File: bench/tmc_tape_model.sv */
`timescale 1ns/10ps
`default_nettype none
module tmc_tape_model
    import tmc_pkg::*;
(
    output var tmc_trk_t o_trk
);
    initial o_trk = '{tim: 1'b1, mark: 1'b0, data: 3'h0};
    // Negative timing step, mark and data set up before the strobe
    task automatic fall(input logic m, input logic [2:0] d);
        o_trk.tim  = 1'b0;
        o_trk.mark = m;
        o_trk.data = d;
    endtask : fall
    task automatic rise();
        o_trk.tim = 1'b1;
    endtask : rise
    // Released read lines do not hold their last level
    task automatic park();
        o_trk.mark = ~o_trk.mark;
        o_trk.data = ~o_trk.data;
    endtask : park
endmodule : tmc_tape_model
`default_nettype wire

/* File: bench/tb_tmc_codec.sv */
`timescale 1ns/10ps
`default_nettype none
`include "tmc_map.svh"
module tb_tmc_codec
    import tmc_pkg::*;
();
    typedef struct packed {
        logic [2:0] u;
        logic [5:0] c;
        logic [7:0] e;
    } tmc_row_t;
    tmc_row_t    rows [10] = '{'{3'h0, 6'h08, 8'h01}, '{3'h1, 6'h3B, 8'h02}, '{3'h2, 6'h12, 8'h04},
                               '{3'h3, 6'h2D, 8'h08}, '{3'h4, 6'h16, 8'h10}, '{3'h5, 6'h25, 8'h20},
                               '{3'h6, 6'h1A, 8'h40}, '{3'h7, 6'h29, 8'h80}, '{3'h0, 6'h15, 8'h01},
                               '{3'h1, 6'h38, 8'h02}};
    logic [35:0] labs [4]  = '{`TMC_LABEL_LAST, `TMC_LABEL_LAST + 36'h1, 36'h0, `TMC_LABEL_FIRST};
    logic        stds [4]  = '{1'b1, 1'b0, 1'b0, 1'b1};
    logic        clk, rst, sel, go, wr, wb_valid, wr_en, wb_ready, underrun, rd_valid;
    logic        aligned, mark_err, label_done, label_std;
    logic [2:0]  unit, wr_cur;
    logic [2:0]  pg = 3'h0;
    bit          pv = 1'b0;
    logic [5:0]  wb_data, rd_byte, last_code, last_byte;
    logic [7:0]  unit_sel;
    logic [35:0] label;
    tmc_trk_t    trk;
    tmc_mark_t   mark;
    int          num_errors = 0;
    int          checked = 0;
    int          n_mark = 0, n_err = 0, n_done = 0, n_und = 0, n_rd = 0;

    tmc_tape_model i_tape (.o_trk(trk));
    tmc_codec i_dut (.i_ref_clk(clk), .i_rst(rst), .i_unit(unit), .i_select(sel), .i_go(go), .i_write(wr),
        .i_trk(trk), .o_unit_sel(unit_sel), .o_wr_cur(wr_cur), .o_wr_en(wr_en), .i_wb_valid(wb_valid),
        .o_wb_ready(wb_ready), .i_wb_data(wb_data), .o_underrun(underrun), .o_rd_valid(rd_valid),
        .o_rd_byte(rd_byte), .o_mark(mark), .o_aligned(aligned), .o_mark_err(mark_err),
        .o_label_done(label_done), .o_label(label), .o_label_std(label_std));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Pulse counters, sampled mid-cycle
    always @(negedge clk)
    begin
        if (mark.valid === 1'b1)
        begin
            n_mark++;
            last_code = mark.code;
        end
        if (rd_valid === 1'b1)
        begin
            last_byte = rd_byte;
            n_rd++;
        end
        n_err  += int'(mark_err === 1'b1);
        n_done += int'(label_done === 1'b1);
        n_und  += int'(underrun === 1'b1);
    end

    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : tally_and_finish

    // One tape position of 64 ns
    task automatic pos(input logic m, input logic [2:0] d);
        i_tape.fall(m, d);
        #32;
        i_tape.rise();
        #32;
    endtask : pos

    task automatic code(input logic [5:0] c, input logic [2:0] d);
        for (int i = 5; i >= 0; i--)
            pos(c[i], d);
    endtask : code

    // Write position: load shows ~g, the previous group shows flipped
    task automatic wpos(input logic [2:0] g);
        i_tape.fall(1'b0, 3'h0);
        #8;
        if (pv)
            chk(wr_cur, pg);
        #24;
        i_tape.rise();
        #12;
        chk(wr_cur ^ g, 3'h7);
        pg = g;
        pv = 1'b1;
        #20;
    endtask : wpos

    initial
    begin
        #50000;
        num_errors++;
        tally_and_finish();
    end

    initial
    begin
        int          n;
        logic [5:0]  b;
        logic [11:0] mk;
        mk = {`TMC_CODE_SPACE, `TMC_CODE_LEND};
        rst = 1'b1;
        sel = 1'b0;
        unit = 3'h0;
        go = 1'b0;
        wr = 1'b0;
        wb_valid = 1'b0;
        wb_data = 6'h00;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        go = 1'b1;
        foreach (rows[i])
        begin
            @(negedge clk);
            unit = rows[i].u;
            sel = 1'b1;
            #3;
            code(rows[i].c, 3'h5);
            #16;
            chk(last_code, rows[i].c);
            chk(last_byte, 6'h2D);
            chk(unit_sel, rows[i].e);
            if (i == 0)
                chk(n_rd, 2);
        end
        chk(wr_en, 1'b0);
        // Stop and restart anywhere: spacers leave alignment clear, a framing mark rebuilds it
        @(negedge clk);
        go = 1'b0;
        i_tape.park();
        repeat (4) @(negedge clk);
        go = 1'b1;
        n = n_mark;
        #3;
        code(`TMC_CODE_SPACE, 3'h2);
        code(`TMC_CODE_SPACE, 3'h2);
        #16;
        chk(n_mark - n, 4);
        chk(aligned, 1'b0);
        chk(last_byte, 6'h12);
        code(`TMC_CODE_DMARK, 3'h2);
        #16;
        chk(aligned, 1'b1);
        chk(n_err, 0);
        n = n_err;
        code(6'h3F, 3'h2);
        #16;
        chk(n_err - n, 1);
        foreach (labs[k])
        begin
            n = n_done;
            code(`TMC_CODE_LSYNC, 3'h0);
            for (int j = 0; j < 12; j++)
                pos(mk[11 - j], labs[k][35 - 3 * j -: 3]);
            #16;
            chk(n_done - n, 1);
            chk(label, labs[k]);
            chk(label_std, stds[k]);
        end
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        chk(unit_sel, 8'h00);
        chk(aligned, 1'b0);
        chk(label_std, 1'b0);
        chk(wb_ready, 1'b1);
        rst = 1'b0;
        go = 1'b0;
        // Fill the buffer while the tape stands still
        n = 0;
        for (int i = 0; i < 17; i++)
        begin
            @(negedge clk);
            n += int'(wb_ready);
            wb_valid = 1'b1;
            wb_data = 6'(i * 5 + 9);
        end
        @(negedge clk);
        wb_valid = 1'b0;
        chk(n, 16);
        chk(wb_ready, 1'b0);
        wr = 1'b1;
        go = 1'b1;
        repeat (2) @(negedge clk);
        chk(wr_en, 1'b1);
        #3;
        for (int i = 0; i < 16; i++)
        begin
            b = 6'(i * 5 + 9);
            wpos(b[5:3]);
            wpos(b[2:0]);
        end
        chk(n_und, 0);
        wpos(3'h0);
        #8;
        chk(wr_cur, 3'h0);
        chk(n_und, 1);
        chk(wb_ready, 1'b1);
        tally_and_finish();
    end
endmodule : tb_tmc_codec
`default_nettype wire
